// >>> core/audio_playback_dac_path.sv
// Playback path: APB registers, rate accumulator, offset mixing and modulator outputs
// Summary of operation
// [R1] Rate word joins 4-bit high, 16-bit low
// [R2] Accumulator rollover requests sample, normal mode
// [R3] Zero rate word idles logic and clocks
// [R4] Converter clock from crystal, not PLL
// [R5] Sample request raises interrupt; software writes samples
// [R6] Mode bit 12 selects 3 or 6 MHz
// [R7] Two modulator bitstreams at 6 Mbit/s
// [R8] Mode bit 11 doubles rate, word limited
// [R9] Software zeroes rate before toggling high rate
// [R10] Fine-tune counter adds extra masked increments
// [R11] Fine-tune count zero disables extra increments
// [R12] Coarse attenuation 6 dB per step
// [R13] Fine gain 0.5 dB steps, 12-15 unity
// [R14] Offset sample 20 bits over two registers
// [R15] Read without full flag sets underrun
// [R16] Full sets on writes, clears when consumed
// [R17] Enable bit switches offset mixing
// [R18] Offset interval is field plus one cycles
// [R19] Offset consumption raises interrupt request
// [R20] Mixed sum saturates to 20-bit signed
// [R21] Software keeps mix under 75% scale
// [R22] Offset held until next taken
// [R23] All registers reset to zero
module audio_playback_dac_path #(
    parameter int ACC_W = 20,
    parameter int MIX_DIV_W = 12
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic sample_request,
    output logic mix_request,
    output logic ext_clock_out,
    output logic left_bitstream_out,
    output logic right_bitstream_out,
    output logic converter_clock_run
);
    logic [15:0] rate_low_q, rate_low_d;
    logic [3:0] rate_high_q, rate_high_d;
    logic [15:0] left_low_q, left_low_d, left_high_q, left_high_d;
    logic [15:0] right_low_q, right_low_d, right_high_q, right_high_d;
    logic [15:0] volume_q, volume_d;
    logic [15:0] mode_q, mode_d;
    logic [12:0] mix_cfg_q, mix_cfg_d;
    logic full_q, full_d, urun_q, urun_d;
    logic [3:0] mix_left_low_q, mix_left_low_d, mix_right_low_q, mix_right_low_d;
    logic [15:0] mix_left_high_q, mix_left_high_d, mix_right_high_q, mix_right_high_d;
    logic [1:0] mix_written_q, mix_written_d;
    logic [19:0] hold_left_q, hold_left_d, hold_right_q, hold_right_d;
    logic [ACC_W-1:0] acc_q, acc_d;
    logic [2:0] tune_q, tune_d;
    logic [2:0] mod_cnt_q, mod_cnt_d;
    logic [1:0] ext_cnt_q, ext_cnt_d;
    logic ext_q, ext_d;
    logic sreq_q, sreq_d, mreq_q, mreq_d;
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;
    logic wr_en, hit;
    logic [15:0] idx;
    logic [19:0] rate_word;
    logic run;
    logic mod_tick;
    logic mix_tick;
    logic [ACC_W:0] acc_sum;
    logic extra;
    logic [19:0] mixed_left, mixed_right;

    // Word index from byte address; sub-word bits are ignored
    assign idx = paddr[17:2];
    assign wr_en = psel && penable && pwrite;
    assign rate_word = {rate_high_q, rate_low_q}; // [R1]
    assign run = (rate_word != 20'h00000); // [R3]
    // Converter clock gate follows the idle state; sourced from the crystal clock alone
    assign converter_clock_run = run; // [R4]

    // Address decode: every mapped index answers, others give a bus error
    always_comb begin
        hit = 1'b1;
        rdata_d = 32'h00000000;
        if (idx == play_pkg::IDX_RATE_LOW) begin
            rdata_d[15:0] = rate_low_q;
        end else if (idx == play_pkg::IDX_RATE_HIGH) begin
            rdata_d[3:0] = rate_high_q;
        end else if (idx == play_pkg::IDX_LEFT_LOW) begin
            rdata_d[15:0] = left_low_q;
        end else if (idx == play_pkg::IDX_LEFT_HIGH) begin
            rdata_d[15:0] = left_high_q;
        end else if (idx == play_pkg::IDX_RIGHT_LOW) begin
            rdata_d[15:0] = right_low_q;
        end else if (idx == play_pkg::IDX_RIGHT_HIGH) begin
            rdata_d[15:0] = right_high_q;
        end else if (idx == play_pkg::IDX_VOLUME) begin
            rdata_d[15:0] = volume_q;
        end else if (idx == play_pkg::IDX_MIX_CFG) begin
            rdata_d[14:0] = {urun_q, full_q, mix_cfg_q};
        end else if (idx == play_pkg::IDX_MIX_LEFT_LOW) begin
            rdata_d[15:12] = mix_left_low_q;
        end else if (idx == play_pkg::IDX_MIX_LEFT_HIGH) begin
            rdata_d[15:0] = mix_left_high_q;
        end else if (idx == play_pkg::IDX_MIX_RIGHT_LOW) begin
            rdata_d[15:12] = mix_right_low_q;
        end else if (idx == play_pkg::IDX_MIX_RIGHT_HIGH) begin
            rdata_d[15:0] = mix_right_high_q;
        end else if (idx == play_pkg::IDX_MODE) begin
            rdata_d[15:0] = mode_q;
        end else if (idx == play_pkg::IDX_STATUS) begin
            rdata_d[19:0] = rate_word[19:0] & 20'h00000 | acc_q[19:0];
        end else begin
            hit = 1'b0;
        end
    end

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_q;

    // Register writes; flags are hardware-set with set winning over clear
    always_comb begin
        rate_low_d = rate_low_q;
        rate_high_d = rate_high_q;
        left_low_d = left_low_q;
        left_high_d = left_high_q;
        right_low_d = right_low_q;
        right_high_d = right_high_q;
        volume_d = volume_q;
        mode_d = mode_q;
        mix_cfg_d = mix_cfg_q;
        mix_left_low_d = mix_left_low_q;
        mix_left_high_d = mix_left_high_q;
        mix_right_low_d = mix_right_low_q;
        mix_right_high_d = mix_right_high_q;
        mix_written_d = mix_written_q;
        full_d = full_q;
        urun_d = urun_q;
        hold_left_d = hold_left_q;
        hold_right_d = hold_right_q;
        if (wr_en) begin
            if (idx == play_pkg::IDX_RATE_LOW) begin
                rate_low_d = pwdata[15:0];
            end else if (idx == play_pkg::IDX_RATE_HIGH) begin
                rate_high_d = pwdata[3:0];
            end else if (idx == play_pkg::IDX_LEFT_LOW) begin
                left_low_d = {pwdata[15:8], 8'h00}; // [R5]
            end else if (idx == play_pkg::IDX_LEFT_HIGH) begin
                left_high_d = pwdata[15:0]; // [R5]
            end else if (idx == play_pkg::IDX_RIGHT_LOW) begin
                right_low_d = {pwdata[15:8], 8'h00};
            end else if (idx == play_pkg::IDX_RIGHT_HIGH) begin
                right_high_d = pwdata[15:0];
            end else if (idx == play_pkg::IDX_VOLUME) begin
                volume_d = pwdata[15:0];
            end else if (idx == play_pkg::IDX_MIX_CFG) begin
                mix_cfg_d = pwdata[12:0];
                if (!pwdata[play_pkg::MIX_URUN_BIT]) begin
                    urun_d = 1'b0;
                end
            end else if (idx == play_pkg::IDX_MIX_LEFT_LOW) begin
                mix_left_low_d = pwdata[15:12]; // [R14]
            end else if (idx == play_pkg::IDX_MIX_LEFT_HIGH) begin
                mix_left_high_d = pwdata[15:0]; // [R14]
                mix_written_d[0] = 1'b1;
            end else if (idx == play_pkg::IDX_MIX_RIGHT_LOW) begin
                mix_right_low_d = pwdata[15:12];
            end else if (idx == play_pkg::IDX_MIX_RIGHT_HIGH) begin
                mix_right_high_d = pwdata[15:0];
                mix_written_d[1] = 1'b1;
            end else if (idx == play_pkg::IDX_MODE) begin
                mode_d = {3'b000, pwdata[12:4], 1'b0, pwdata[2:0]};
            end
        end
        // Consumption by the mixer; the sample is held until the next take
        if (mix_tick) begin
            if (!full_q) begin
                urun_d = 1'b1; // [R15]
            end else begin
                hold_left_d = {mix_left_high_q, mix_left_low_q}; // [R22]
                hold_right_d = {mix_right_high_q, mix_right_low_q};
            end
            full_d = 1'b0; // [R16]
        end
        // Both channels written sets full; this beats a same-cycle consume
        if (mix_written_d == 2'b11) begin
            full_d = 1'b1; // [R16]
            mix_written_d = 2'b00;
        end
    end

    // Mix rate divider runs only while the offset path is on
    rate_divider #(
        .W(MIX_DIV_W)
    ) u_mix_div (
        .clk(clk),
        .nrst(nrst),
        .run(mix_cfg_q[play_pkg::MIX_ENA_BIT] && run), // [R17]
        .limit(mix_cfg_q[MIX_DIV_W-1:0]), // [R18]
        .tick(mix_tick)
    );

    // Rate accumulator with fine-tune extra increments
    always_comb begin
        extra = (mode_q[2:0] != 3'b000) && (tune_q != 3'h7) && mode_q[play_pkg::MODE_MASK_LSB + tune_q]; // [R10] [R11]
        tune_d = tune_q;
        acc_d = acc_q;
        sreq_d = 1'b0;
        acc_sum = {1'b0, acc_q};
        if (run) begin
            // High rate mode adds the doubled rate word once per modulator tick to double fs
            if (mod_tick) begin
                if (mode_q[play_pkg::MODE_HIGH_RATE_BIT]) begin
                    acc_sum = {1'b0, acc_q} + {rate_word, 1'b0} + {20'h00000, extra}; // [R8]
                end else begin
                    acc_sum = {1'b0, acc_q} + {1'b0, rate_word} + {20'h00000, extra}; // [R2]
                end
                acc_d = acc_sum[ACC_W-1:0];
                sreq_d = acc_sum[ACC_W]; // [R2] [R5]
                if (mode_q[2:0] == 3'b000 || tune_q >= mode_q[2:0]) begin
                    tune_d = 3'b000;
                end else begin
                    tune_d = tune_q + 3'b001;
                end
            end
        end else begin
            acc_d = '0; // [R3]
            tune_d = 3'b000;
        end
    end

    // Modulator bit clock and external converter clock from the crystal domain
    always_comb begin
        mod_cnt_d = mod_cnt_q;
        mod_tick = 1'b0;
        ext_cnt_d = ext_cnt_q;
        ext_d = ext_q;
        if (!run) begin
            mod_cnt_d = 3'b000; // [R3]
            ext_cnt_d = 2'b00;
            ext_d = 1'b0;
        end else begin
            if (mod_cnt_q == 3'(play_pkg::MOD_DIV - 1)) begin
                mod_cnt_d = 3'b000;
                mod_tick = 1'b1; // [R7]
            end else begin
                mod_cnt_d = mod_cnt_q + 3'b001;
            end
            if (mod_tick) begin
                if (ext_cnt_q >= (mode_q[play_pkg::MODE_EXT3M_BIT] ? 2'(play_pkg::EXT_3M_HALF - 1)
                                                                   : 2'(play_pkg::EXT_6M_HALF - 1))) begin
                    ext_cnt_d = 2'b00;
                    ext_d = !ext_q; // [R6]
                end else begin
                    ext_cnt_d = ext_cnt_q + 2'b01;
                end
            end
        end
        mreq_d = mix_tick && full_q; // [R19]
    end

    channel_volume u_left (
        .clk(clk),
        .nrst(nrst),
        .run(run),
        .mod_tick(mod_tick),
        .sample({left_high_q, left_low_q[15:8]}),
        .coarse(volume_q[play_pkg::VOL_LCOARSE_LSB +: 4]),
        .fine(volume_q[play_pkg::VOL_LFINE_LSB +: 4]),
        .offset(hold_left_q),
        .offset_on(mix_cfg_q[play_pkg::MIX_ENA_BIT]),
        .mixed(mixed_left),
        .bit_out(left_bitstream_out)
    );

    channel_volume u_right (
        .clk(clk),
        .nrst(nrst),
        .run(run),
        .mod_tick(mod_tick),
        .sample({right_high_q, right_low_q[15:8]}),
        .coarse(volume_q[play_pkg::VOL_RCOARSE_LSB +: 4]),
        .fine(volume_q[play_pkg::VOL_RFINE_LSB +: 4]),
        .offset(hold_right_q),
        .offset_on(mix_cfg_q[play_pkg::MIX_ENA_BIT]),
        .mixed(mixed_right),
        .bit_out(right_bitstream_out)
    );

    assign sample_request = sreq_q;
    assign mix_request = mreq_q;
    assign ext_clock_out = ext_q;

    // State registers, all zero at reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rate_low_q <= play_pkg::RESET_VALUE; // [R23]
            rate_high_q <= 4'h0;
            left_low_q <= play_pkg::RESET_VALUE;
            left_high_q <= play_pkg::RESET_VALUE;
            right_low_q <= play_pkg::RESET_VALUE;
            right_high_q <= play_pkg::RESET_VALUE;
            volume_q <= play_pkg::RESET_VALUE;
            mode_q <= play_pkg::RESET_VALUE;
            mix_cfg_q <= 13'h0000;
            mix_left_low_q <= 4'h0;
            mix_left_high_q <= play_pkg::RESET_VALUE;
            mix_right_low_q <= 4'h0;
            mix_right_high_q <= play_pkg::RESET_VALUE;
            mix_written_q <= 2'b00;
            full_q <= 1'b0;
            urun_q <= 1'b0;
            hold_left_q <= 20'h00000;
            hold_right_q <= 20'h00000;
            acc_q <= '0;
            tune_q <= 3'b000;
            mod_cnt_q <= 3'b000;
            ext_cnt_q <= 2'b00;
            ext_q <= 1'b0;
            sreq_q <= 1'b0;
            mreq_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            rate_low_q <= rate_low_d;
            rate_high_q <= rate_high_d;
            left_low_q <= left_low_d;
            left_high_q <= left_high_d;
            right_low_q <= right_low_d;
            right_high_q <= right_high_d;
            volume_q <= volume_d;
            mode_q <= mode_d;
            mix_cfg_q <= mix_cfg_d;
            mix_left_low_q <= mix_left_low_d;
            mix_left_high_q <= mix_left_high_d;
            mix_right_low_q <= mix_right_low_d;
            mix_right_high_q <= mix_right_high_d;
            mix_written_q <= mix_written_d;
            full_q <= full_d;
            urun_q <= urun_d;
            hold_left_q <= hold_left_d;
            hold_right_q <= hold_right_d;
            acc_q <= acc_d;
            tune_q <= tune_d;
            mod_cnt_q <= mod_cnt_d;
            ext_cnt_q <= ext_cnt_d;
            ext_q <= ext_d;
            sreq_q <= sreq_d;
            mreq_q <= mreq_d;
            // Read data registered in the setup cycle, stable through the access cycle
            if (psel && !penable && !pwrite) begin
                prdata_q <= rdata_d;
            end
        end
    end
endmodule

// >>> core/channel_volume.sv
// One channel: volume scaling, mixing of the offset sample, saturation, modulator
module channel_volume (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic mod_tick,
    input wire logic [23:0] sample,
    input wire logic [3:0] coarse,
    input wire logic [3:0] fine,
    input wire logic [19:0] offset,
    input wire logic offset_on,
    output logic [19:0] mixed,
    output logic bit_out
);
    logic [19:0] mixed_d;
    logic [20:0] acc_q;
    logic [20:0] acc_d;
    logic bit_q;
    logic bit_d;
    logic signed [23:0] shifted;
    logic signed [31:0] gained;
    logic signed [20:0] sum;
    logic [7:0] gain;

    // Fine gain in 0.5 dB steps, Q7 multipliers; codes past 11 give unity
    always_comb begin
        case (fine)
            4'h1: gain = 8'h88;
            4'h2: gain = 8'h8F;
            4'h3: gain = 8'h98;
            4'h4: gain = 8'hA1;
            4'h5: gain = 8'hAA;
            4'h6: gain = 8'hB4;
            4'h7: gain = 8'hBF;
            4'h8: gain = 8'hCB;
            4'h9: gain = 8'hD7;
            4'hA: gain = 8'hE4;
            4'hB: gain = 8'hF1;
            default: gain = 8'h80; // [R13]
        endcase
    end

    // Coarse attenuation is an arithmetic shift, 6 dB per step, then saturating mix
    always_comb begin
        shifted = $signed(sample) >>> coarse; // [R12]
        gained = (shifted * $signed({1'b0, gain})) >>> 11;
        sum = 21'(gained);
        if (offset_on) begin
            sum = 21'($signed(gained[20:0]) + $signed({offset[19], offset}));
        end
        if (gained > 32'sd524287 || sum > 21'sd524287) begin
            mixed_d = 20'h7FFFF; // [R20]
        end else if (gained < -32'sd524288 || sum < -21'sd524288) begin
            mixed_d = 20'h80000; // [R20]
        end else begin
            mixed_d = sum[19:0];
        end
    end

    // First order sigma-delta modulator at the bit rate
    always_comb begin
        acc_d = acc_q;
        bit_d = bit_q;
        if (!run) begin
            acc_d = '0;
            bit_d = 1'b0;
        end else if (mod_tick) begin
            acc_d = acc_q + {1'b0, mixed ^ 20'h80000}; // [R7]
            bit_d = acc_d[20];
            acc_d[20] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mixed <= '0;
            acc_q <= '0;
            bit_q <= 1'b0;
        end else begin
            mixed <= run ? mixed_d : 20'h00000;
            acc_q <= acc_d;
            bit_q <= bit_d;
        end
    end
    assign bit_out = bit_q;
endmodule

// >>> core/play_pkg.sv
// Register map, field layout and timing constants of the playback path
package play_pkg;
    // Printed offsets are word indices; byte address is four times the index
    localparam logic [15:0] IDX_RATE_LOW = 16'hFC34;
    localparam logic [15:0] IDX_RATE_HIGH = 16'hFC35;
    localparam logic [15:0] IDX_LEFT_LOW = 16'hFC36;
    localparam logic [15:0] IDX_LEFT_HIGH = 16'hFC37;
    localparam logic [15:0] IDX_RIGHT_LOW = 16'hFC38;
    localparam logic [15:0] IDX_RIGHT_HIGH = 16'hFC39;
    localparam logic [15:0] IDX_VOLUME = 16'hFEC0;
    localparam logic [15:0] IDX_MIX_CFG = 16'hFEC1;
    localparam logic [15:0] IDX_MIX_LEFT_LOW = 16'hFEC2;
    localparam logic [15:0] IDX_MIX_LEFT_HIGH = 16'hFEC3;
    localparam logic [15:0] IDX_MIX_RIGHT_LOW = 16'hFEC4;
    localparam logic [15:0] IDX_MIX_RIGHT_HIGH = 16'hFEC5;
    localparam logic [15:0] IDX_MODE = 16'hFED9;
    localparam logic [15:0] IDX_STATUS = 16'hFEDA;
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    // Mode register fields
    localparam int MODE_EXT3M_BIT = 12;
    localparam int MODE_HIGH_RATE_BIT = 11;
    localparam int MODE_MASK_LSB = 4;
    localparam int MODE_COUNT_LSB = 0;
    // Mix config fields
    localparam int MIX_URUN_BIT = 14;
    localparam int MIX_FULL_BIT = 13;
    localparam int MIX_ENA_BIT = 12;
    // Volume fields
    localparam int VOL_LFINE_LSB = 12;
    localparam int VOL_LCOARSE_LSB = 8;
    localparam int VOL_RFINE_LSB = 4;
    localparam int VOL_RCOARSE_LSB = 0;
    // Modulator bit clock and external clock
    localparam int CLK_HZ = 40000000;
    localparam int MOD_RATE_HZ = 6000000;
    localparam int MOD_DIV = CLK_HZ / MOD_RATE_HZ;
    localparam int EXT_6M_HALF = 1;
    localparam int EXT_3M_HALF = 2;
    localparam int FINE_MAX = 11;
endpackage

// >>> core/rate_divider.sv
// Enable pulse generator dividing the clock by a programmable count plus one
module rate_divider #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic tick
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Counter restarts when stopped so the first interval is full length
    always_comb begin
        cnt_d = cnt_q;
        tick = 1'b0;
        if (!run) begin
            cnt_d = '0;
        end else if (cnt_q >= limit) begin
            cnt_d = '0;
            tick = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// >>> tb/audio_playback_dac_path_tb.sv
// Register-level testbench of the playback path
module audio_playback_dac_path_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, req, mreq, ext, lbit, rbit, run, er;
    int error_cnt = 0, cmp_count = 0, req_n = 0, mix_n = 0, cycles = 0;
    int l_e, r_e, x_r, b0, b1, b2, b3;
    audio_playback_dac_path dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_request(req), .mix_request(mreq), .ext_clock_out(ext), .left_bitstream_out(lbit),
        .right_bitstream_out(rbit), .converter_clock_run(run));
    dac_modulator_model conv_u (.clk(clk), .nrst(nrst), .left_bits(lbit), .right_bits(rbit), .ext_clk(ext),
        .left_edges(l_e), .right_edges(r_e), .ext_rises(x_r));
    always #12.5 clk = ~clk;
    // Pulse counters and a hang limit well above the planned run
    always @(posedge clk) begin
        cycles++;
        req_n += int'(req === 1'b1);
        mix_n += int'(mreq === 1'b1);
        if (cycles == 40000) begin
            error_cnt++;
            conclude();
        end
    end
    task conclude;
        $display("Errors %0d in %0d checks", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task rng(input string nm, input int v, input int lo, input int hi);
        chk(nm, 32'(v >= lo && v <= hi), 32'h00000001);
    endtask
    // One APB transfer; held until pready is sampled high, then released a cycle
    task apb(input logic w, input logic [15:0] idx, input logic [15:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Every register except status reads zero after reset; an unmapped index is refused
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, play_pkg::IDX_RATE_LOW + 16'(i), 16'h0000);
            chk("main reg", rd, 32'h00000000);
            apb(1'b0, play_pkg::IDX_VOLUME + 16'(i), 16'h0000);
            chk("vol mix reg", rd, 32'h00000000);
        end
        apb(1'b0, play_pkg::IDX_MODE, 16'h0000);
        chk("mode reg", rd, 32'h00000000);
        apb(1'b0, 16'hFC3A, 16'h0000);
        chk("unmapped", {31'h00000000, er}, 32'h00000001);
        apb(1'b1, play_pkg::IDX_VOLUME, 16'hFFFF);
        apb(1'b0, play_pkg::IDX_VOLUME, 16'h0000);
        chk("volume", rd, 32'h0000FFFF);
        apb(1'b1, play_pkg::IDX_MIX_LEFT_LOW, 16'hF000);
        apb(1'b0, play_pkg::IDX_MIX_LEFT_LOW, 16'h0000);
        chk("offset nibble", rd, 32'h0000F000);
        // Mask set but count zero: no extra steps, accumulator stays on 0x8000 multiples
        apb(1'b1, play_pkg::IDX_MODE, 16'h07F0);
        apb(1'b1, play_pkg::IDX_RATE_LOW, 16'h8000);
        chk("run", {31'h00000000, run}, 32'h00000001);
        b0 = req_n;
        b1 = x_r;
        b2 = l_e;
        b3 = r_e;
        repeat (1920) @(posedge clk);
        rng("req normal", req_n - b0, 9, 11);
        rng("ext 6M", x_r - b1, 159, 161);
        rng("left bits", l_e - b2, 1, 9999);
        rng("right bits", r_e - b3, 1, 9999);
        apb(1'b0, play_pkg::IDX_STATUS, 16'h0000);
        chk("no extra", rd & 32'h00007FFF, 32'h00000000);
        // 3 MHz clock and one extra step every other tick
        apb(1'b1, play_pkg::IDX_MODE, 16'h1011);
        b1 = x_r;
        repeat (1920) @(posedge clk);
        rng("ext 3M", x_r - b1, 79, 81);
        apb(1'b0, play_pkg::IDX_STATUS, 16'h0000);
        chk("extra", 32'(rd[14:0] != 15'h0000), 32'h00000001);
        // Zero rate idles everything
        apb(1'b1, play_pkg::IDX_RATE_LOW, 16'h0000);
        chk("idle", {31'h00000000, run}, 32'h00000000);
        b0 = req_n;
        b1 = x_r;
        repeat (300) @(posedge clk);
        rng("idle req", req_n - b0, 0, 0);
        rng("idle ext", x_r - b1, 0, 0);
        apb(1'b1, play_pkg::IDX_MODE, 16'h0800);
        apb(1'b1, play_pkg::IDX_RATE_LOW, 16'h8000);
        b0 = req_n;
        repeat (1920) @(posedge clk);
        rng("req high", req_n - b0, 19, 21);
        // Offset stream: underrun when empty, then full, then one consumption
        apb(1'b1, play_pkg::IDX_MIX_CFG, 16'h1FFF);
        repeat (4200) @(posedge clk);
        apb(1'b0, play_pkg::IDX_MIX_CFG, 16'h0000);
        chk("underrun", rd & 32'h00007000, 32'h00005000);
        apb(1'b1, play_pkg::IDX_MIX_CFG, 16'h1FFF);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, play_pkg::IDX_MIX_LEFT_LOW + 16'(i), 16'h1000);
        end
        apb(1'b0, play_pkg::IDX_MIX_CFG, 16'h0000);
        chk("full set", rd & 32'h00002000, 32'h00002000);
        b0 = mix_n;
        repeat (4200) @(posedge clk);
        rng("mix req", mix_n - b0, 1, 1);
        apb(1'b0, play_pkg::IDX_MIX_CFG, 16'h0000);
        chk("full clear", rd & 32'h00002000, 32'h00000000);
        conclude();
    end
endmodule

// >>> tb/dac_modulator_model.sv
// Converter-side model: counts bitstream and external clock activity
module dac_modulator_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic left_bits,
    input wire logic right_bits,
    input wire logic ext_clk,
    output int left_edges,
    output int right_edges,
    output int ext_rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic l_q, r_q, e_q;
    // Only listens; the real modulator never answers the block
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {l_q, r_q, e_q} <= 3'h0;
            left_edges <= 0;
            right_edges <= 0;
            ext_rises <= 0;
        end else begin
            {l_q, r_q, e_q} <= {left_bits, right_bits, ext_clk};
            left_edges <= left_edges + int'(left_bits != l_q);
            right_edges <= right_edges + int'(right_bits != r_q);
            ext_rises <= ext_rises + int'(ext_clk && !e_q);
        end
    end
endmodule

// >>> tb/play_path_sva.sv
// Port checker for the playback path
module play_path_sva #(
    parameter int ACC_W = 20,
    parameter int MIX_DIV_W = 12
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sample_request,
    input wire logic mix_request,
    input wire logic ext_clock_out,
    input wire logic left_bitstream_out,
    input wire logic right_bitstream_out,
    input wire logic converter_clock_run
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_rate_starts_run: assert property (psel && penable && pwrite && pwdata[15:0] != 16'h0000
        && paddr == {play_pkg::IDX_RATE_LOW, 2'b00} |=> converter_clock_run) else $error("rate write left idle");
    a_request_spacing: assert property (sample_request |=> !sample_request [*5])
        else $error("sample requests too close");
    a_idle_no_request: assert property (!converter_clock_run [*2] |-> !sample_request)
        else $error("sample request while idle");
    a_idle_clock_low: assert property (!converter_clock_run [*2] |-> !ext_clock_out)
        else $error("external clock runs while idle");
    a_ext_tick_hold: assert property ($changed(ext_clock_out) && converter_clock_run
        |=> (!converter_clock_run || $stable(ext_clock_out)) [*5]) else $error("external clock too fast");
    a_bit_tick_hold: assert property ($changed(left_bitstream_out) && converter_clock_run
        |=> (!converter_clock_run || $stable(left_bitstream_out)) [*5]) else $error("bitstream too fast");
    a_mix_pulse_once: assert property (mix_request |=> !mix_request)
        else $error("offset request longer than one cycle");
    a_mix_needs_run: assert property (mix_request |-> $past(converter_clock_run))
        else $error("offset taken while idle");
endmodule
bind audio_playback_dac_path play_path_sva #(.ACC_W(ACC_W), .MIX_DIV_W(MIX_DIV_W)) chk_u (.clk(clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_request(sample_request),
    .mix_request(mix_request), .ext_clock_out(ext_clock_out), .left_bitstream_out(left_bitstream_out),
    .right_bitstream_out(right_bitstream_out), .converter_clock_run(converter_clock_run));
